// ===== common/csf_pkg.sv
// Shared constants and types of the clock source failover block.
// Assumes a single 20 MHz system clock and an AXI4-Lite register slave.
`default_nettype none

package csf_pkg;

   // Clock and failure timing
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned FAIL_PERIOD_NS = 1000000;
   // Longest tolerated gap between source edges, rounded down
   localparam int unsigned FAIL_CYCLES    = FAIL_PERIOD_NS / CLK_PERIOD_NS;

   // Register map (byte addresses)
   localparam int unsigned ADDR_W        = 8;
   localparam logic [7:0]  OFS_OSC_CTL   = 8'h00;
   localparam logic [7:0]  OFS_STATUS    = 8'h04;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
   localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;

   // Oscillator control layout
   localparam int unsigned BIT_PREC_EN   = 7;
   localparam int unsigned BIT_WDT_EN    = 5;
   localparam int unsigned BIT_PFAIL_EN  = 4;
   localparam int unsigned BIT_WFAIL_EN  = 3;
   localparam int unsigned SEL_MSB       = 2;
   localparam logic [7:0]  OSC_CTL_RST   = 8'hA0;
   localparam logic [7:0]  OSC_CTL_WMASK = 8'hBF;

   // Unlock keys
   localparam logic [7:0]  UNLOCK_KEY1   = 8'hE7;
   localparam logic [7:0]  UNLOCK_KEY2   = 8'h18;

   // Clock source select codes
   localparam logic [2:0]  SEL_PREC_FAST = 3'h0;
   localparam logic [2:0]  SEL_PREC_SLOW = 3'h1;
   localparam logic [2:0]  SEL_WDT       = 3'h3;
   localparam logic [2:0]  SEL_EXT_PIN   = 3'h4;

   // Status register layout
   localparam int unsigned ST_FAILOVER   = 0;
   localparam int unsigned ST_PFAIL      = 1;
   localparam int unsigned ST_WFAIL      = 2;
   localparam int unsigned ST_OPEN       = 3;
   localparam int unsigned ST_KEY1       = 4;

   // Interrupt status and mask layout
   localparam int unsigned IRQ_W         = 2;
   localparam int unsigned IRQ_PFAIL     = 0;
   localparam int unsigned IRQ_WFAIL     = 1;
   localparam logic [1:0]  IRQ_MASK_RST  = 2'h0;

   // AXI responses
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum {LK_LOCKED, LK_KEY1, LK_OPEN} csf_lock_t;
   typedef enum {REG_NONE, REG_OSC, REG_STAT, REG_ISTAT, REG_IMASK} csf_reg_t;

endpackage

`default_nettype wire

// ===== design/csf_fail_detect.sv
// Oscillator failure detector: flags a source with no rising edge within
// LIMIT system clock cycles. Assumes osc_i is asynchronous to clk_sys_i.
`default_nettype none

module csf_fail_detect #(
   parameter int unsigned LIMIT = csf_pkg::FAIL_CYCLES
) (
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   // Control and source
   input  wire logic enable_i,
   input  wire logic osc_i,
   // Result
   output logic      fail_o,
   output logic      fail_evt_o
);

   logic        sync1_r;
   logic        sync2_r;
   logic        sync3_r;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;
   logic        fail_r;
   logic        fail_nxt;
   logic        evt_r;
   logic        evt_nxt;
   logic        rise;

   assign rise = sync2_r & ~sync3_r;

   always_comb begin
      cnt_nxt  = cnt_r;
      fail_nxt = fail_r;
      if (!enable_i) begin
         cnt_nxt  = 32'h0;
         fail_nxt = 1'b0;
      end else if (rise) begin
         cnt_nxt  = 32'h0;
         fail_nxt = 1'b0;
      end else if (cnt_r >= LIMIT - 1) begin
         fail_nxt = 1'b1;
      end else begin
         cnt_nxt  = cnt_r + 32'h1;
      end
      evt_nxt = fail_nxt & ~fail_r;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
         cnt_r   <= 32'h0;
         fail_r  <= 1'b0;
         evt_r   <= 1'b0;
      end else begin
         sync1_r <= osc_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
         cnt_r   <= cnt_nxt;
         fail_r  <= fail_nxt;
         evt_r   <= evt_nxt;
      end
   end

   assign fail_o     = fail_r;
   assign fail_evt_o = evt_r;

endmodule // csf_fail_detect

`default_nettype wire

// ===== design/csf_top.sv
// Clock source selection with primary failure detection and failover to
// the watchdog oscillator. Assumes the clock mux, the oscillators and the
// processor sit outside; they follow the select and enable outputs.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`default_nettype none

// Overview of operation
// - Primary failure switches system to watchdog oscillator
// - Primary failure raises non-maskable clock failure event
// - Failover only while watchdog oscillator enabled
// - No failover when watchdog already selected
// - Failure when source slower than about 1 kHz
// - Precision oscillator enable bit switches it
// - Reserved bits written zero, read zero
// - Watchdog oscillator enable bit switches it
// - Primary fail enable gates detection and recovery
// - Watchdog fail enable gates its detection
// - Select 000: precision oscillator at 5.53 MHz
// - Select 001: precision oscillator 32 kHz setting
// - Select 011: watchdog oscillator clocks system
// - Select 100: external clock pin clocks system
// - Updates need E7H then 18H unlock writes
module csf_top #(
   parameter int unsigned FAIL_LIMIT = csf_pkg::FAIL_CYCLES
) (
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  s_axi_awaddr_i,
   input  wire logic        s_axi_awvalid_i,
   output logic             s_axi_awready_o,
   input  wire logic [31:0] s_axi_wdata_i,
   input  wire logic [3:0]  s_axi_wstrb_i,
   input  wire logic        s_axi_wvalid_i,
   output logic             s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp_o,
   output logic             s_axi_bvalid_o,
   input  wire logic        s_axi_bready_i,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr_i,
   input  wire logic        s_axi_arvalid_i,
   output logic             s_axi_arready_o,
   output logic [31:0]      s_axi_rdata_o,
   output logic [1:0]       s_axi_rresp_o,
   output logic             s_axi_rvalid_o,
   input  wire logic        s_axi_rready_i,
   // Oscillator monitors
   input  wire logic        sys_clk_mon_i,
   input  wire logic        wdt_osc_clk_i,
   // Oscillator control
   output logic             precision_osc_enable_o,
   output logic             precision_osc_slow_o,
   output logic             watchdog_osc_enable_o,
   output logic [2:0]       system_clock_source_select_o,
   output logic             external_clock_pin_sel_o,
   // Events
   output logic             failover_active_o,
   output logic             clk_fail_nmi_o,
   output logic             irq_o
);

   function automatic csf_pkg::csf_reg_t csf_decode(input logic [7:0] a);
      csf_pkg::csf_reg_t r;
      r = csf_pkg::REG_NONE;
      if (a == csf_pkg::OFS_OSC_CTL) begin
         r = csf_pkg::REG_OSC;
      end else if (a == csf_pkg::OFS_STATUS) begin
         r = csf_pkg::REG_STAT;
      end else if (a == csf_pkg::OFS_IRQ_STAT) begin
         r = csf_pkg::REG_ISTAT;
      end else if (a == csf_pkg::OFS_IRQ_MASK) begin
         r = csf_pkg::REG_IMASK;
      end
      return r;
   endfunction

   logic [7:0]         osc_r;
   logic [7:0]         osc_nxt;
   csf_pkg::csf_lock_t lock_r;
   csf_pkg::csf_lock_t lock_nxt;
   logic [1:0]         istat_r;
   logic [1:0]         istat_nxt;
   logic [1:0]         imask_r;
   logic [1:0]         imask_nxt;
   logic               fo_r;
   logic               fo_nxt;
   logic               nmi_r;
   logic               nmi_nxt;
   logic [2:0]         sel_r;
   logic [2:0]         sel_nxt;
   logic               bvalid_r;
   logic               bvalid_nxt;
   logic [1:0]         bresp_r;
   logic [1:0]         bresp_nxt;
   logic               rvalid_r;
   logic               rvalid_nxt;
   logic [1:0]         rresp_r;
   logic [1:0]         rresp_nxt;
   logic [31:0]        rdata_r;
   logic [31:0]        rdata_nxt;

   logic               wr_take;
   logic               rd_take;
   logic               pfail;
   logic               pfail_evt;
   logic               wfail;
   logic               wfail_evt;
   logic               pdet_en;
   logic               wdet_en;
   csf_pkg::csf_reg_t  wsel;
   csf_pkg::csf_reg_t  rsel;

   // Once failed over, the monitor follows the slow watchdog clock and
   // would only report the failure again, so primary detection pauses.
   assign pdet_en = osc_r[csf_pkg::BIT_PFAIL_EN] & ~fo_r;
   assign wdet_en = osc_r[csf_pkg::BIT_WFAIL_EN]
                  & osc_r[csf_pkg::BIT_WDT_EN];

   csf_fail_detect #(
      .LIMIT      (FAIL_LIMIT)
   ) u_pdet (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .enable_i   (pdet_en),
      .osc_i      (sys_clk_mon_i),
      .fail_o     (pfail),
      .fail_evt_o (pfail_evt)
   );

   csf_fail_detect #(
      .LIMIT      (FAIL_LIMIT)
   ) u_wdet (
      .clk_sys_i  (clk_sys_i),
      .rst_n_i    (rst_n_i),
      .enable_i   (wdet_en),
      .osc_i      (wdt_osc_clk_i),
      .fail_o     (wfail),
      .fail_evt_o (wfail_evt)
   );

   assign wr_take = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_r;
   assign rd_take = s_axi_arvalid_i & ~rvalid_r;
   assign wsel    = csf_decode(s_axi_awaddr_i);
   assign rsel    = csf_decode(s_axi_araddr_i);

   always_comb begin
      osc_nxt    = osc_r;
      lock_nxt   = lock_r;
      istat_nxt  = istat_r;
      imask_nxt  = imask_r;
      fo_nxt     = fo_r;
      nmi_nxt    = 1'b0;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;

      if (bvalid_r && s_axi_bready_i) begin
         bvalid_nxt = 1'b0;
      end
      if (rvalid_r && s_axi_rready_i) begin
         rvalid_nxt = 1'b0;
      end

      if (wr_take) begin
         bvalid_nxt = 1'b1;
         bresp_nxt  = csf_pkg::RESP_OKAY;
         if (wsel == csf_pkg::REG_OSC) begin
            if (s_axi_wstrb_i[0]) begin
               case (lock_r)
                  csf_pkg::LK_LOCKED: begin
                     if (s_axi_wdata_i[7:0] == csf_pkg::UNLOCK_KEY1) begin
                        lock_nxt = csf_pkg::LK_KEY1;
                     end
                  end
                  csf_pkg::LK_KEY1: begin
                     if (s_axi_wdata_i[7:0] == csf_pkg::UNLOCK_KEY2) begin
                        lock_nxt = csf_pkg::LK_OPEN;
                     end else if (s_axi_wdata_i[7:0]
                                  != csf_pkg::UNLOCK_KEY1) begin
                        lock_nxt = csf_pkg::LK_LOCKED;
                     end
                  end
                  csf_pkg::LK_OPEN: begin
                     // Reserved bit is never stored
                     osc_nxt  = s_axi_wdata_i[7:0]
                              & csf_pkg::OSC_CTL_WMASK;
                     lock_nxt = csf_pkg::LK_LOCKED;
                     fo_nxt   = 1'b0;
                  end
                  default: begin
                     lock_nxt = csf_pkg::LK_LOCKED;
                  end
               endcase
            end
         end else if (wsel == csf_pkg::REG_ISTAT) begin
            if (s_axi_wstrb_i[0]) begin
               istat_nxt = istat_r & ~s_axi_wdata_i[1:0];
            end
         end else if (wsel == csf_pkg::REG_IMASK) begin
            if (s_axi_wstrb_i[0]) begin
               imask_nxt = s_axi_wdata_i[1:0];
            end
         end else if (wsel == csf_pkg::REG_STAT) begin
            bresp_nxt = csf_pkg::RESP_OKAY;
         end else begin
            bresp_nxt = csf_pkg::RESP_SLVERR;
         end
      end

      // Events after the clears so that a set in the same cycle wins
      if (pfail_evt) begin
         istat_nxt[csf_pkg::IRQ_PFAIL] = 1'b1;
         nmi_nxt = 1'b1;
         if (osc_r[csf_pkg::BIT_WDT_EN] &&
             osc_r[2:0] != csf_pkg::SEL_WDT) begin
            fo_nxt = 1'b1;
         end
      end
      if (wfail_evt) begin
         istat_nxt[csf_pkg::IRQ_WFAIL] = 1'b1;
      end
      // Recovery is released as soon as its enables go away
      if (!osc_nxt[csf_pkg::BIT_PFAIL_EN] ||
          !osc_nxt[csf_pkg::BIT_WDT_EN]) begin
         fo_nxt = 1'b0;
      end

      if (fo_nxt) begin
         sel_nxt = csf_pkg::SEL_WDT;
      end else begin
         sel_nxt = osc_nxt[csf_pkg::SEL_MSB:0];
      end

      if (rd_take) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = csf_pkg::RESP_OKAY;
         rdata_nxt  = 32'h0;
         if (rsel == csf_pkg::REG_OSC) begin
            rdata_nxt[7:0] = osc_r;
         end else if (rsel == csf_pkg::REG_STAT) begin
            rdata_nxt[csf_pkg::ST_FAILOVER] = fo_r;
            rdata_nxt[csf_pkg::ST_PFAIL]    = pfail;
            rdata_nxt[csf_pkg::ST_WFAIL]    = wfail;
            rdata_nxt[csf_pkg::ST_OPEN]     = (lock_r == csf_pkg::LK_OPEN);
            rdata_nxt[csf_pkg::ST_KEY1]     = (lock_r == csf_pkg::LK_KEY1);
         end else if (rsel == csf_pkg::REG_ISTAT) begin
            rdata_nxt[1:0] = istat_r;
         end else if (rsel == csf_pkg::REG_IMASK) begin
            rdata_nxt[1:0] = imask_r;
         end else begin
            rresp_nxt = csf_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         osc_r    <= csf_pkg::OSC_CTL_RST;
         lock_r   <= csf_pkg::LK_LOCKED;
         istat_r  <= 2'h0;
         imask_r  <= csf_pkg::IRQ_MASK_RST;
         fo_r     <= 1'b0;
         nmi_r    <= 1'b0;
         sel_r    <= csf_pkg::SEL_PREC_FAST;
         bvalid_r <= 1'b0;
         bresp_r  <= csf_pkg::RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r  <= csf_pkg::RESP_OKAY;
         rdata_r  <= 32'h0;
      end else begin
         osc_r    <= osc_nxt;
         lock_r   <= lock_nxt;
         istat_r  <= istat_nxt;
         imask_r  <= imask_nxt;
         fo_r     <= fo_nxt;
         nmi_r    <= nmi_nxt;
         sel_r    <= sel_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r  <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r  <= rresp_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Bus handshakes
   assign s_axi_awready_o = wr_take;
   assign s_axi_wready_o  = wr_take;
   assign s_axi_bvalid_o  = bvalid_r;
   assign s_axi_bresp_o   = bresp_r;
   assign s_axi_arready_o = ~rvalid_r;
   assign s_axi_rvalid_o  = rvalid_r;
   assign s_axi_rresp_o   = rresp_r;
   assign s_axi_rdata_o   = rdata_r;

   // Oscillator control; the precision oscillator stays under software
   // control even when unselected, for power saving.
   assign precision_osc_enable_o = osc_r[csf_pkg::BIT_PREC_EN];
   assign watchdog_osc_enable_o  = osc_r[csf_pkg::BIT_WDT_EN];
   assign precision_osc_slow_o   =
      (sel_r == csf_pkg::SEL_PREC_SLOW);
   assign external_clock_pin_sel_o =
      (sel_r == csf_pkg::SEL_EXT_PIN);
   assign system_clock_source_select_o = sel_r;
   assign failover_active_o      = fo_r;
   assign clk_fail_nmi_o         = nmi_r;
   assign irq_o                  = |(istat_r & imask_r);

endmodule // csf_top

`default_nettype wire

// ===== verif/csf_top_properties.sv
// Concurrent checks of the clock source failover block, bound to csf_top.
// Assumes one clock domain with the asynchronous active-low reset.
`default_nettype none

module csf_top_properties #(
   parameter int unsigned FAIL_LIMIT = 16
) (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       rst_n_i,
   // Observed
   input  wire logic       sys_clk_mon_i,
   input  wire logic [2:0] system_clock_source_select_o,
   input  wire logic       precision_osc_slow_o,
   input  wire logic       external_clock_pin_sel_o,
   input  wire logic       watchdog_osc_enable_o,
   input  wire logic       failover_active_o,
   input  wire logic       clk_fail_nmi_o,
   input  wire logic       irq_o
);
   logic [31:0] quiet_r;
   logic [31:0] quiet_nxt;
   logic        mon_r;

   // Cycles since the monitored source last moved, saturating
   always_comb begin
      quiet_nxt = quiet_r + 32'h1;
      if (sys_clk_mon_i != mon_r) quiet_nxt = 32'h0;
      if (quiet_r == 32'hFFFF_FFFF) quiet_nxt = quiet_r;
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         quiet_r <= 32'h0;
         mon_r   <= 1'b0;
      end else begin
         quiet_r <= quiet_nxt;
         mon_r   <= sys_clk_mon_i;
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   nmi_single_pulse_a: assert property (
      clk_fail_nmi_o |=> !clk_fail_nmi_o) else $error("nmi longer than one");
   failover_needs_nmi_a: assert property (
      $rose(failover_active_o) |-> clk_fail_nmi_o)
      else $error("lone failover");
   failover_select_a: assert property (
      failover_active_o |-> system_clock_source_select_o == 3'h3)
      else $error("failover not on watchdog osc");
   failover_wdt_on_a: assert property (
      failover_active_o |-> watchdog_osc_enable_o) else $error("wdt osc off");
   nmi_after_quiet_a: assert property (
      clk_fail_nmi_o |-> quiet_r >= FAIL_LIMIT) else $error("early nmi");
   no_wdt_failover_a: assert property (
      $rose(failover_active_o) |-> $past(system_clock_source_select_o) != 3'h3)
      else $error("failover from watchdog source");
   slow_decode_a: assert property (
      precision_osc_slow_o == (system_clock_source_select_o == 3'h1))
      else $error("slow setting decode");
   ext_decode_a: assert property (
      external_clock_pin_sel_o == (system_clock_source_select_o == 3'h4))
      else $error("external pin decode");

   cover property (clk_fail_nmi_o && failover_active_o);
   cover property (clk_fail_nmi_o && !failover_active_o);
   cover property (irq_o);

endmodule // csf_top_properties

bind csf_top csf_top_properties #(.FAIL_LIMIT(FAIL_LIMIT))
   csf_top_properties_inst (.*);

`default_nettype wire

// ===== verif/tb_csf_top.sv
// Self-checking bench of the clock source failover block.
// Assumes the bench is AXI4-Lite master and drives both oscillator monitors.
`default_nettype none

module tb_csf_top;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int unsigned FL = 16;
   logic        clk_sys_i, rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i;
   logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
   logic        sys_clk_mon_i, wdt_osc_clk_i, s_axi_awready_o;
   logic        s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
   logic        s_axi_rvalid_o, precision_osc_enable_o, precision_osc_slow_o;
   logic        watchdog_osc_enable_o, external_clock_pin_sel_o;
   logic        failover_active_o, clk_fail_nmi_o, irq_o, mon_run, wdt_run;
   logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, v;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rdat;
   logic [3:0]  s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
   logic [2:0]  system_clock_source_select_o;
   logic [2:0]  sels [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
   int          errors, checks, n, t;

   csf_top #(.FAIL_LIMIT(FL)) csf_top_inst (.*);

   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // Free-running sources unless a scenario stops one
   always @(posedge clk_sys_i) begin
      if (mon_run) sys_clk_mon_i <= ~sys_clk_mon_i;
      if (wdt_run) wdt_osc_clk_i <= ~wdt_osc_clk_i;
   end

   task automatic wrap_up();
      $display("errors %0d checks %0d", errors, checks);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s exp %h got %h", nm, exp, got);
      end
   endtask

   // One bounded clock step; a hang ends the run
   task automatic tick();
      @(posedge clk_sys_i);
      n++;
      if (n > 300) begin
         errors++;
         wrap_up();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      n = 0;
      do tick(); while (!s_axi_awready_o);
      s_axi_awvalid_i <= 1'b0;
      s_axi_wvalid_i <= 1'b0;
      s_axi_bready_i <= 1'b1;
      do tick(); while (!s_axi_bvalid_o);
      resp = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      n = 0;
      do tick(); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 1'b0;
      s_axi_rready_i <= 1'b1;
      do tick(); while (!s_axi_rvalid_o);
      rdat = s_axi_rdata_o;
      resp = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
   endtask

   task automatic osc(input logic [7:0] d);
      wr(8'h00, {24'h0, csf_pkg::UNLOCK_KEY1});
      wr(8'h00, {24'h0, csf_pkg::UNLOCK_KEY2});
      wr(8'h00, {24'h0, d});
   endtask

   // Program, stop the primary source, count cycles up to the nmi
   task automatic stop_wait(input logic [7:0] d);
      osc(d);
      mon_run <= 1'b0;
      t = 0;
      n = 0;
      do begin
         tick();
         t++;
      end while (!clk_fail_nmi_o);
      mon_run <= 1'b1;
      chk("nmi_lat", t >= FL && t <= FL + 8, 1'b1);
   endtask

   function automatic logic [31:0] ctl_exp(input logic [7:0] d);
      return {24'h0, d & 8'hBF};
   endfunction

   initial begin
      {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
      {s_axi_arvalid_i, s_axi_rready_i, sys_clk_mon_i, wdt_osc_clk_i} = 4'h0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
      s_axi_wstrb_i = 4'hF;
      {mon_run, wdt_run, errors, checks} = {2'h3, 64'h0};
      void'($urandom(32'h02C1));
      repeat (12) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      @(posedge clk_sys_i);
      rd(8'h00);
      chk("ctl_rst", rdat, {24'h0, csf_pkg::OSC_CTL_RST});
      // Keys out of order leave the register alone
      wr(8'h00, 32'h18);
      wr(8'h00, 32'hE7);
      wr(8'h00, 32'h55);
      rd(8'h00);
      chk("ctl_locked", rdat, 32'hA0);
      // Keys split by another register access still unlock
      wr(8'h00, 32'hE7);
      wr(8'h0C, 32'h0);
      rd(8'h04);
      chk("st_key1", rdat, 32'h10);
      wr(8'h00, 32'h18);
      rd(8'h04);
      chk("st_open", rdat, 32'h08);
      wr(8'h00, 32'hC1);
      rd(8'h00);
      chk("ctl_split", rdat, ctl_exp(8'hC1));
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         v[4:3] = 2'h0;
         v[2:0] = sels[i % 4];
         osc(v);
         chk("sel", system_clock_source_select_o, v[2:0]);
         chk("prec_en", precision_osc_enable_o, v[7]);
         chk("slow", precision_osc_slow_o, v[2:0] == 3'h1);
         chk("wdt_en", watchdog_osc_enable_o, v[5]);
         chk("ext", external_clock_pin_sel_o, v[2:0] == 3'h4);
         rd(8'h00);
         chk("ctl_rd", rdat, ctl_exp(v));
      end
      wr(8'h10, 32'h1);
      chk("wr_unmapped", resp, csf_pkg::RESP_SLVERR);
      rd(8'h10);
      chk("rd_unmapped", rdat, 32'h0);
      chk("rd_resp", resp, csf_pkg::RESP_SLVERR);
      stop_wait(8'hB0);
      chk("failover", failover_active_o, 1'b1);
      chk("fo_sel", system_clock_source_select_o, 3'h3);
      rd(8'h04);
      chk("st_failover", rdat, 32'h1);
      wr(8'h0C, 32'h1);
      rd(8'h08);
      chk("pfail_stat", rdat, 32'h1);
      chk("irq_on", irq_o, 1'b1);
      wr(8'h08, 32'h1);
      rd(8'h08);
      chk("irq_clear", {rdat[0], irq_o}, 2'h0);
      stop_wait(8'h90);
      chk("no_wdt_osc", failover_active_o, 1'b0);
      chk("no_wdt_sel", system_clock_source_select_o, 3'h0);
      stop_wait(8'hB3);
      chk("wdt_source", failover_active_o, 1'b0);
      chk("wdt_src_sel", system_clock_source_select_o, 3'h3);
      osc(8'hA0);
      mon_run <= 1'b0;
      t = 0;
      n = 0;
      repeat (60) begin
         tick();
         t += int'(clk_fail_nmi_o);
      end
      mon_run <= 1'b1;
      chk("detect_off", t, 32'h0);
      osc(8'hA8);
      wr(8'h08, 32'h3);
      wr(8'h0C, 32'h2);
      wdt_run <= 1'b0;
      n = 0;
      do tick(); while (!irq_o);
      wdt_run <= 1'b1;
      rd(8'h08);
      chk("wfail_stat", rdat, 32'h2);
      wrap_up();
   end

endmodule // tb_csf_top

`default_nettype wire
